/* exv_params.svh */
// constants for the exception vector and priority unit
`ifndef EXV_PARAMS_SVH
`define EXV_PARAMS_SVH

`define EXV_OFF_CTRL 8'h00
`define EXV_OFF_PSW 8'h04
`define EXV_OFF_STATUS 8'h08
`define EXV_OFF_VECTOR 8'h0c

`define EXV_CTRL_BASE_HIGH_BIT 0
`define EXV_CTRL_RESET 1'b0

`define EXV_PSW_MODE_LSB 0
`define EXV_PSW_F_BIT 6
`define EXV_PSW_I_BIT 7
`define EXV_PSW_A_BIT 8

`define EXV_BASE_LOW 32'h0000_0000
`define EXV_BASE_HIGH 32'hffff_0000

`define EXV_VOFF_RESET 8'h00
`define EXV_VOFF_UND 8'h04
`define EXV_VOFF_SVC 8'h08
`define EXV_VOFF_PABT 8'h0c
`define EXV_VOFF_DABT 8'h10
`define EXV_VOFF_RSVD 8'h14
`define EXV_VOFF_IRQ 8'h18
`define EXV_VOFF_FINT 8'h1c

`define EXV_MODE_USR 5'h10
`define EXV_MODE_FINT 5'h11
`define EXV_MODE_IRQ 5'h12
`define EXV_MODE_SVC 5'h13
`define EXV_MODE_ABT 5'h17
`define EXV_MODE_UND 5'h1b

`define EXV_COP_CLASS_XFER 4'he
`define EXV_COP_CLASS_LDST 3'h6
`define EXV_COP_SC_NUM 4'hf
`define EXV_USER_PRIM 4'hd
`define EXV_USER_OP2_RW 3'h2
`define EXV_USER_OP2_RO 3'h3

`endif

/* exv_pkg.sv */
// types shared by the exception vector and priority unit
package exv_pkg;
    typedef enum logic [2:0] {
        EXV_EXC_NONE = 3'h0,
        EXV_EXC_RESET = 3'h1,
        EXV_EXC_UND = 3'h2,
        EXV_EXC_SVC = 3'h3,
        EXV_EXC_PABT = 3'h4,
        EXV_EXC_DABT = 3'h5,
        EXV_EXC_IRQ = 3'h6,
        EXV_EXC_FINT = 3'h7
    } exv_exc_t;

    typedef enum logic [1:0] {
        EXV_ST_IDLE = 2'b01,
        EXV_ST_CHAIN = 2'b10
    } exv_state_t;
endpackage : exv_pkg

/* exv_cop_if.sv */
// carrier between the core logic and the coprocessor decoder
`timescale 1ns/1ps
interface exv_cop_if;
    logic valid;
    logic [31:0] instr;
    logic privileged;
    logic undef;
    logic is_read;
    logic is_write;
    logic [3:0] primary_reg_sel;
    logic [3:0] secondary_reg_sel;
    logic [2:0] op_variant_sel;
    logic [2:0] op_group_sel;

    modport dec (
        input valid, instr, privileged,
        output undef, is_read, is_write, primary_reg_sel, secondary_reg_sel,
        output op_variant_sel, op_group_sel
    );
    modport core (
        output valid, instr, privileged,
        input undef, is_read, is_write, primary_reg_sel, secondary_reg_sel,
        input op_variant_sel, op_group_sel
    );
endinterface : exv_cop_if

/* exv_cop_decode.sv */
// decoder for system_control_coproc instructions
`timescale 1ns/1ps
`include "exv_params.svh"
module exv_cop_decode (
    input wire logic pclk, // clock, checks only
    input wire logic presetn, // reset, checks only
    exv_cop_if.dec cop // decode request and result
);
    logic sc_hit;
    logic is_xfer;
    logic is_data;
    logic is_ldst;
    logic user_ok;

    always_comb begin
        sc_hit = cop.valid && (cop.instr[11:8] == `EXV_COP_SC_NUM);
        is_xfer = (cop.instr[27:24] == `EXV_COP_CLASS_XFER) && cop.instr[4];
        is_data = (cop.instr[27:24] == `EXV_COP_CLASS_XFER) && !cop.instr[4];
        is_ldst = (cop.instr[27:25] == `EXV_COP_CLASS_LDST);
        // only the thread id slots are open to user code
        user_ok = (cop.instr[19:16] == `EXV_USER_PRIM) && (cop.instr[23:21] == 3'h0)
            && (cop.instr[3:0] == 4'h0) && ((cop.instr[7:5] == `EXV_USER_OP2_RW)
            || ((cop.instr[7:5] == `EXV_USER_OP2_RO) && cop.instr[20]));
        cop.undef = sc_hit && (is_data || is_ldst
            || (is_xfer && !cop.privileged && !user_ok));
        cop.is_read = sc_hit && is_xfer && cop.instr[20];
        cop.is_write = sc_hit && is_xfer && !cop.instr[20];
        cop.primary_reg_sel = cop.instr[19:16];
        cop.secondary_reg_sel = cop.instr[3:0];
        cop.op_variant_sel = cop.instr[7:5];
        cop.op_group_sel = cop.instr[23:21];
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_data_undef;
        cop.valid && cop.instr[11:8] == 4'hf && cop.instr[27:24] == 4'he && !cop.instr[4]
            |-> cop.undef && !cop.is_read && !cop.is_write;
    endproperty
    a_data_undef: assert property (p_data_undef) else $error("data op not undefined");

    property p_user_priv;
        cop.valid && cop.instr[11:8] == 4'hf && cop.instr[27:24] == 4'he && cop.instr[4]
            && !cop.privileged && cop.instr[19:16] != 4'hd |-> cop.undef;
    endproperty
    a_user_priv: assert property (p_user_priv) else $error("user access not trapped");

    property p_dir;
        (cop.is_read || cop.is_write) |-> (cop.is_read == cop.instr[20])
            && (cop.is_write != cop.instr[20]);
    endproperty
    a_dir: assert property (p_dir) else $error("direction bit misread");

    property p_priv_ok;
        cop.valid && cop.privileged && cop.instr[11:8] == 4'hf && cop.instr[27:24] == 4'he
            && cop.instr[4] |-> !cop.undef;
    endproperty
    a_priv_ok: assert property (p_priv_ok) else $error("privileged access trapped");

    c_user_trap: cover property (cop.undef && cop.is_read);
endmodule : exv_cop_decode

/* exv_unit.sv */
// exception vector, priority and entry logic with apb status registers
// Notes on behaviour
// - the vector base is zero when the base-high control bit is 0 and 0xffff0000 when it is 1.
// - each exception adds its own fixed offset to the base, and 0x14 is never used.
// - reset/svc enter supervisor, undefined undef, aborts abort, each interrupt its own mode.
// - entry sets i always, a for reset/aborts/irq/fast interrupt, f for reset/fast interrupt.
// - priority: reset, precise abort, fast int, irq, imprecise abort, prefetch abort, the rest.
// - breakpoint, undefined and supervisor call never arise together.
// - a precise abort with an enabled fast interrupt takes abort entry then fast entry at once.
// - data, load and store coprocessor ops to the control coprocessor are undefined.
// - unprivileged register transfers to privileged-only locations are undefined.
// - the primary select picks the register, the secondary and variant selects the action.
// - the direction bit reads the register when 1 and writes it when 0.
// - a pending imprecise abort is held while its mask is set and taken once it clears.
// - the active-low irq is ignored while masked and sampled at each instruction end otherwise.
`timescale 1ns/1ps
`include "exv_params.svh"
module exv_unit (
    input wire logic pclk, // core clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic irq_n, // irq request pin, active low
    input wire logic fast_interrupt_n, // fast interrupt pin, active low
    input wire logic instr_end, // pulse at each instruction boundary
    input wire logic precise_dabort, // precise data abort of this instruction
    input wire logic imprecise_dabort, // pulse, imprecise abort event
    input wire logic prefetch_abort, // prefetch abort of this instruction
    input wire logic breakpoint_op, // breakpoint decode
    input wire logic undef_instr, // undefined decode
    input wire logic supervisor_call, // supervisor call decode
    input wire logic cop_valid, // coprocessor instruction present
    input wire logic [31:0] cop_instr, // coprocessor instruction word
    output logic entry_valid, // pulse, exception entry
    output logic [31:0] entry_vector, // vector address of entry
    output logic [2:0] entry_code, // exception taken
    output logic [4:0] psw_mode, // current mode
    output logic normal_request_hold, // irq mask
    output logic imprecise_err_hold, // imprecise abort mask
    output logic quick_irq_block, // fiq mask
    output logic cop_undef, // coprocessor op traps
    output logic coproc_read_op, // register read decoded
    output logic coproc_write_op, // register write decoded
    output logic [3:0] primary_reg_sel, // selected register
    output logic [3:0] secondary_reg_sel, // action select
    output logic [2:0] op_variant_sel // action variant
);
    exv_cop_if cop_bus ();

    logic [1:0] irq_sync_reg;
    logic [1:0] fint_sync_reg;
    logic base_high_reg, base_high_next;
    logic [4:0] mode_reg, mode_next;
    logic i_reg, i_next;
    logic a_reg, a_next;
    logic f_reg, f_next;
    logic imp_pend_reg, imp_pend_next;
    logic reset_pend_reg, reset_pend_next;
    exv_pkg::exv_state_t state_reg, state_next;
    logic entry_reg, entry_next;
    logic [31:0] vector_reg, vector_next;
    exv_pkg::exv_exc_t code_reg, code_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic cop_undef_reg, cop_rd_reg, cop_wr_reg;
    logic [3:0] prim_reg, sec_reg;
    logic [2:0] op2_reg;

    exv_pkg::exv_exc_t exc_sel;
    logic imp_taken;
    logic fint_act;
    logic irq_act;
    logic apb_wr;
    logic [31:0] base;
    logic [7:0] voff;

    assign cop_bus.valid = cop_valid;
    assign cop_bus.instr = cop_instr;
    assign cop_bus.privileged = (mode_reg != `EXV_MODE_USR);

    exv_cop_decode u_dec (
        .pclk(pclk),
        .presetn(presetn),
        .cop(cop_bus)
    );

    // pins come from outside the core clock domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_sync_reg <= 2'h3;
            fint_sync_reg <= 2'h3;
        end else begin
            irq_sync_reg <= {irq_sync_reg[0], irq_n};
            fint_sync_reg <= {fint_sync_reg[0], fast_interrupt_n};
        end
    end

    // exception selection and entry
    always_comb begin
        fint_act = !fint_sync_reg[1] && !f_reg;
        irq_act = !irq_sync_reg[1] && !i_reg;
        exc_sel = exv_pkg::EXV_EXC_NONE;
        imp_taken = 1'b0;
        state_next = exv_pkg::EXV_ST_IDLE;
        case (state_reg)
            exv_pkg::EXV_ST_IDLE: begin
                if (reset_pend_reg) begin
                    exc_sel = exv_pkg::EXV_EXC_RESET;
                end else if (instr_end) begin
                    if (precise_dabort) begin
                        exc_sel = exv_pkg::EXV_EXC_DABT;
                        if (fint_act) begin
                            state_next = exv_pkg::EXV_ST_CHAIN;
                        end
                    end else if (fint_act) begin
                        exc_sel = exv_pkg::EXV_EXC_FINT;
                    end else if (irq_act) begin
                        exc_sel = exv_pkg::EXV_EXC_IRQ;
                    end else if (imp_pend_reg && !a_reg) begin
                        exc_sel = exv_pkg::EXV_EXC_DABT;
                        imp_taken = 1'b1;
                    end else if (prefetch_abort || breakpoint_op) begin
                        // breakpoint behaves as a prefetch abort
                        exc_sel = exv_pkg::EXV_EXC_PABT;
                    end else if (undef_instr || cop_bus.undef) begin
                        exc_sel = exv_pkg::EXV_EXC_UND;
                    end else if (supervisor_call) begin
                        exc_sel = exv_pkg::EXV_EXC_SVC;
                    end
                end
            end
            exv_pkg::EXV_ST_CHAIN: begin
                // abort entry leaves f clear, so the fast entry follows straight away
                exc_sel = exv_pkg::EXV_EXC_FINT;
            end
            default: begin
                state_next = exv_pkg::EXV_ST_IDLE;
            end
        endcase

        base = base_high_reg ? `EXV_BASE_HIGH : `EXV_BASE_LOW;
        case (exc_sel)
            exv_pkg::EXV_EXC_UND: voff = `EXV_VOFF_UND;
            exv_pkg::EXV_EXC_SVC: voff = `EXV_VOFF_SVC;
            exv_pkg::EXV_EXC_PABT: voff = `EXV_VOFF_PABT;
            exv_pkg::EXV_EXC_DABT: voff = `EXV_VOFF_DABT;
            exv_pkg::EXV_EXC_IRQ: voff = `EXV_VOFF_IRQ;
            exv_pkg::EXV_EXC_FINT: voff = `EXV_VOFF_FINT;
            default: voff = `EXV_VOFF_RESET;
        endcase

        apb_wr = psel && penable && pwrite && pready_reg;
        base_high_next = base_high_reg;
        mode_next = mode_reg;
        i_next = i_reg;
        a_next = a_reg;
        f_next = f_reg;
        if (apb_wr && paddr == `EXV_OFF_CTRL) begin
            base_high_next = pwdata[`EXV_CTRL_BASE_HIGH_BIT];
        end
        if (apb_wr && paddr == `EXV_OFF_PSW) begin
            mode_next = pwdata[`EXV_PSW_MODE_LSB +: 5];
            i_next = pwdata[`EXV_PSW_I_BIT];
            a_next = pwdata[`EXV_PSW_A_BIT];
            f_next = pwdata[`EXV_PSW_F_BIT];
        end
        // entry wins over a software write in the same cycle for the mode and each mask bit that it sets
        if (exc_sel != exv_pkg::EXV_EXC_NONE) begin
            i_next = 1'b1;
            case (exc_sel)
                exv_pkg::EXV_EXC_RESET: begin
                    mode_next = `EXV_MODE_SVC;
                    a_next = 1'b1;
                    f_next = 1'b1;
                end
                exv_pkg::EXV_EXC_UND: mode_next = `EXV_MODE_UND;
                exv_pkg::EXV_EXC_SVC: mode_next = `EXV_MODE_SVC;
                exv_pkg::EXV_EXC_IRQ: begin
                    mode_next = `EXV_MODE_IRQ;
                    a_next = 1'b1;
                end
                exv_pkg::EXV_EXC_FINT: begin
                    mode_next = `EXV_MODE_FINT;
                    a_next = 1'b1;
                    f_next = 1'b1;
                end
                default: begin
                    mode_next = `EXV_MODE_ABT;
                    a_next = 1'b1;
                end
            endcase
        end

        // a new event beats the clear caused by taking the old one
        imp_pend_next = (imp_pend_reg && !imp_taken) || imprecise_dabort;
        reset_pend_next = 1'b0;
        entry_next = (exc_sel != exv_pkg::EXV_EXC_NONE);
        vector_next = entry_next ? (base | {24'h0, voff}) : vector_reg;
        code_next = entry_next ? exc_sel : code_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_high_reg <= `EXV_CTRL_RESET;
            mode_reg <= `EXV_MODE_SVC;
            i_reg <= 1'b1;
            a_reg <= 1'b1;
            f_reg <= 1'b1;
            imp_pend_reg <= 1'b0;
            reset_pend_reg <= 1'b1;
            state_reg <= exv_pkg::EXV_ST_IDLE;
            entry_reg <= 1'b0;
            vector_reg <= 32'h0;
            code_reg <= exv_pkg::EXV_EXC_NONE;
        end else begin
            base_high_reg <= base_high_next;
            mode_reg <= mode_next;
            i_reg <= i_next;
            a_reg <= a_next;
            f_reg <= f_next;
            imp_pend_reg <= imp_pend_next;
            reset_pend_reg <= reset_pend_next;
            state_reg <= state_next;
            entry_reg <= entry_next;
            vector_reg <= vector_next;
            code_reg <= code_next;
        end
    end

    // apb slave: no wait states, read data captured in the setup cycle
    always_comb begin
        pready_next = psel && !penable;
        prdata_next = prdata_reg;
        pslverr_next = 1'b0;
        if (psel && !penable) begin
            pslverr_next = 1'b0;
            case (paddr)
                `EXV_OFF_CTRL: prdata_next = {31'h0, base_high_reg};
                `EXV_OFF_PSW: prdata_next = {23'h0, a_reg, i_reg, f_reg, 1'b0, mode_reg};
                `EXV_OFF_STATUS: prdata_next = {27'h0, state_reg == exv_pkg::EXV_ST_CHAIN,
                    code_reg, imp_pend_reg};
                `EXV_OFF_VECTOR: prdata_next = vector_reg;
                default: begin
                    prdata_next = 32'h0;
                    pslverr_next = 1'b1;
                end
            endcase
        end else if (psel && penable) begin
            pslverr_next = pslverr_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            cop_undef_reg <= 1'b0;
            cop_rd_reg <= 1'b0;
            cop_wr_reg <= 1'b0;
            prim_reg <= 4'h0;
            sec_reg <= 4'h0;
            op2_reg <= 3'h0;
        end else begin
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            cop_undef_reg <= cop_bus.undef;
            cop_rd_reg <= cop_bus.is_read;
            cop_wr_reg <= cop_bus.is_write;
            prim_reg <= cop_bus.primary_reg_sel;
            sec_reg <= cop_bus.secondary_reg_sel;
            op2_reg <= cop_bus.op_variant_sel;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign entry_valid = entry_reg;
    assign entry_vector = vector_reg;
    assign entry_code = code_reg;
    assign psw_mode = mode_reg;
    assign normal_request_hold = i_reg;
    assign imprecise_err_hold = a_reg;
    assign quick_irq_block = f_reg;
    assign cop_undef = cop_undef_reg;
    assign coproc_read_op = cop_rd_reg;
    assign coproc_write_op = cop_wr_reg;
    assign primary_reg_sel = prim_reg;
    assign secondary_reg_sel = sec_reg;
    assign op_variant_sel = op2_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_base;
        entry_reg |-> vector_reg[31:16] == ($past(base_high_reg) ? 16'hffff : 16'h0000);
    endproperty
    a_base: assert property (p_base) else $error("vector base wrong");

    property p_offset;
        entry_reg |-> vector_reg[7:0] != 8'h14 && (code_reg != exv_pkg::EXV_EXC_FINT
            || vector_reg[7:0] == 8'h1c) && (code_reg != exv_pkg::EXV_EXC_UND
            || vector_reg[7:0] == 8'h04);
    endproperty
    a_offset: assert property (p_offset) else $error("vector offset wrong");

    property p_mode;
        entry_reg |-> (code_reg == exv_pkg::EXV_EXC_UND) == (mode_reg == 5'h1b)
            && (code_reg != exv_pkg::EXV_EXC_DABT || mode_reg == 5'h17);
    endproperty
    a_mode: assert property (p_mode) else $error("entry mode wrong");

    property p_masks;
        entry_reg |-> i_reg && (code_reg == exv_pkg::EXV_EXC_UND
            || code_reg == exv_pkg::EXV_EXC_SVC || a_reg);
    endproperty
    a_masks: assert property (p_masks) else $error("entry masks not set");

    property p_unchanged;
        ##1 (entry_reg && code_reg == exv_pkg::EXV_EXC_SVC && !$past(apb_wr))
            |-> f_reg == $past(f_reg) && a_reg == $past(a_reg);
    endproperty
    a_unchanged: assert property (p_unchanged) else $error("mask bit changed");

    property p_prio;
        instr_end && precise_dabort && !reset_pend_reg && state_reg == exv_pkg::EXV_ST_IDLE
            |=> entry_reg && code_reg == exv_pkg::EXV_EXC_DABT;
    endproperty
    a_prio: assert property (p_prio) else $error("precise abort not first");

    property p_chain;
        instr_end && precise_dabort && !fint_sync_reg[1] && !f_reg && !reset_pend_reg
            && state_reg == exv_pkg::EXV_ST_IDLE
            |=> code_reg == exv_pkg::EXV_EXC_DABT ##1 entry_reg
            && code_reg == exv_pkg::EXV_EXC_FINT && vector_reg[7:0] == 8'h1c;
    endproperty
    a_chain: assert property (p_chain) else $error("fast entry not chained after abort");

    property p_imp_hold;
        imp_pend_reg && a_reg |=> imp_pend_reg;
    endproperty
    a_imp_hold: assert property (p_imp_hold) else $error("masked imprecise abort lost");

    property p_irq_mask;
        entry_reg && code_reg == exv_pkg::EXV_EXC_IRQ |-> !$past(i_reg) && $past(instr_end);
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq taken while masked");

    c_chain: cover property (code_reg == exv_pkg::EXV_EXC_DABT
        ##1 code_reg == exv_pkg::EXV_EXC_FINT);
    c_imp: cover property (imp_taken);
    c_high: cover property (entry_reg && base_high_reg);
endmodule : exv_unit

/* exv_pipe_model.sv */
// pipeline-side model that raises exception decodes and coprocessor words
`timescale 1ns/1ps
module exv_pipe_model (
    input wire logic pclk, // core clock
    output logic instr_end, // instruction boundary pulse
    output logic [4:0] ev, // svc, und, breakpoint_op, pabt, precise dabt
    output logic imp, // imprecise abort pulse
    output logic cop_valid, // coprocessor word present
    output logic [31:0] cop_instr // coprocessor word
);
    initial begin
        instr_end = 1'b0;
        ev = 5'h00;
        imp = 1'b0;
        cop_valid = 1'b0;
        cop_instr = 32'h0000_0000;
    end
    // callers pass at most one of the three decode kinds at a time
    task step(input logic [4:0] e);
        @(posedge pclk);
        instr_end <= 1'b1;
        ev <= e;
        cop_valid <= 1'b0;
        @(posedge pclk);
        instr_end <= 1'b0;
        ev <= 5'h00;
        repeat (3) @(posedge pclk);
    endtask : step
    // unused select fields stay zero in every word handed over except ed900f00 and ed800f00, whose bits 23:21 are 4
    task cop(input logic [31:0] w);
        @(posedge pclk);
        cop_valid <= 1'b1;
        cop_instr <= w;
        @(posedge pclk);
        @(posedge pclk);
    endtask : cop
    task pulse;
        @(posedge pclk);
        imp <= 1'b1;
        @(posedge pclk);
        imp <= 1'b0;
    endtask : pulse
endmodule : exv_pipe_model

/* testbench.sv */
// self-checking bench for the exception vector and priority unit
`timescale 1ns/1ps
`include "exv_params.svh"
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, irq_n, fast_interrupt_n;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata, q, cop_instr, entry_vector;
    logic pready, pslverr, e, instr_end, imp, cop_valid, entry_valid;
    logic ni, ai, fi, cu, rd, wr;
    logic [4:0] ev, psw_mode;
    logic [2:0] entry_code, ov;
    logic [3:0] pr, sr;
    logic [4:0] evt [4] = '{5'h04, 5'h08, 5'h10, 5'h02};
    logic [2:0] cod [4] = '{3'h4, 3'h2, 3'h3, 3'h4};
    logic [7:0] off [4] = '{8'h0c, 8'h04, 8'h08, 8'h0c};
    logic [4:0] mde [4] = '{5'h17, 5'h1b, 5'h13, 5'h17};
    logic [31:0] ldst [3] = '{32'hee010f00, 32'hed900f00, 32'hed800f00};
    int err_count = 0;
    int check_count = 0;
    int ev_cnt = 0;
    int n0;
    always #5 pclk = ~pclk;
    always @(posedge pclk)
        if (entry_valid === 1'b1)
            ev_cnt <= ev_cnt + 1;
    exv_unit DUT (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .irq_n, .fast_interrupt_n, .instr_end, .precise_dabort(ev[0]),
        .imprecise_dabort(imp), .prefetch_abort(ev[1]), .breakpoint_op(ev[2]),
        .undef_instr(ev[3]), .supervisor_call(ev[4]), .cop_valid, .cop_instr,
        .entry_valid, .entry_vector,
        .entry_code, .psw_mode, .normal_request_hold(ni), .imprecise_err_hold(ai),
        .quick_irq_block(fi), .cop_undef(cu), .coproc_read_op(rd), .coproc_write_op(wr),
        .primary_reg_sel(pr), .secondary_reg_sel(sr), .op_variant_sel(ov)
    );
    exv_pipe_model PIPE (.pclk, .instr_end, .ev, .imp, .cop_valid, .cop_instr);
    task stop_test;
        if (err_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            $display("ERROR %s exp %h got %h", nm, x, s);
            err_count++;
        end
    endtask : chk
    task ent(input logic [2:0] c, input logic [31:0] v, input logic [4:0] m);
        chk("code", entry_code, c);
        chk("vector", entry_vector, v);
        chk("mode", psw_mode, m);
    endtask : ent
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // bounded wait: ready, data and error are taken at the edge that sees ready
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (k == 20) begin
            err_count++;
            stop_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    initial begin
        {psel, penable, pwrite, irq_n, fast_interrupt_n, paddr, pwdata} <= {5'b00011, 40'h0};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        ent(3'h1, `EXV_BASE_LOW, `EXV_MODE_SVC);
        chk("aif", {ai, fi, ni}, 3'b111);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", e, 1'b1);
        chk("rdata", q, 32'h0);
        for (int i = 0; i < 4; i++) begin
            PIPE.step(evt[i]);
            ent(cod[i], {24'h0, off[i]}, mde[i]);
            chk("i", ni, 1'b1);
        end
        apb(1'b1, `EXV_OFF_CTRL, 32'h1);
        apb(1'b1, `EXV_OFF_PSW, 32'h10);
        PIPE.cop(32'hee110f10);
        chk("undef_usr", cu, 1'b1);
        chk("rd", rd, 1'b1);
        for (int i = 0; i < 3; i++) begin
            PIPE.cop(ldst[i]);
            chk("undef_op", cu, 1'b1);
        end
        apb(1'b1, `EXV_OFF_PSW, 32'h13);
        PIPE.cop(32'hee010f32);
        chk("undef_ok", cu, 1'b0);
        chk("rw", {rd, wr}, 2'b01);
        chk("sel", {pr, sr, ov}, {4'h1, 4'h2, 3'h1});
        // imprecise abort parked while its mask is up
        apb(1'b1, `EXV_OFF_PSW, 32'h113);
        PIPE.pulse();
        n0 = ev_cnt;
        PIPE.step(5'h00);
        chk("held", ev_cnt, n0);
        apb(1'b1, `EXV_OFF_PSW, 32'h13);
        PIPE.step(5'h00);
        ent(3'h5, 32'hffff_0010, `EXV_MODE_ABT);
        chk("aif", {ai, fi, ni}, 3'b101);
        apb(1'b0, `EXV_OFF_VECTOR, 32'h0);
        chk("vec_rd", q, 32'hffff_0010);
        fast_interrupt_n <= 1'b0;
        irq_n <= 1'b0;
        apb(1'b1, `EXV_OFF_PSW, 32'h13);
        n0 = ev_cnt;
        PIPE.step(5'h03);
        chk("chain", ev_cnt, n0 + 2);
        ent(3'h7, 32'hffff_001c, `EXV_MODE_FINT);
        chk("aif", {ai, fi, ni}, 3'b111);
        fast_interrupt_n <= 1'b1;
        apb(1'b1, `EXV_OFF_PSW, 32'h13);
        PIPE.step(5'h02);
        ent(3'h6, 32'hffff_0018, `EXV_MODE_IRQ);
        chk("f", fi, 1'b0);
        PIPE.step(5'h10);
        ent(3'h3, 32'hffff_0008, `EXV_MODE_SVC);
        stop_test();
    end
endmodule : testbench
